// [rtl/tpc_pwm_gen.sv]
// Purpose: Three-phase PWM generator with output chopper
// Assumes: Software side drives the strobes synchronously to CLK_SYS_I
// Notes:   Dead-time insertion lives outside; pairs are plain complements when three_route or compl_en is set

`timescale 1ns/100ps

module tpc_pwm_gen (
   // Clock and reset
   input  wire logic                         CLK_SYS_I,
   input  wire logic                         RSTN_I,
   // Control
   input  wire logic                         CLK_EN_I,
   input  wire tpc_pkg::tpc_timebase_t       TIMEBASE_I,
   input  wire tpc_pkg::tpc_chop_cfg_t       CHOP_CFG_I,
   input  wire logic [tpc_pkg::REP_W-1:0]    REPEAT_COUNT_I,
   // Compare pair write and read
   input  wire logic [1:0]                   CMP_SEL_I,
   input  wire logic                         CMP_LO_WR_I,
   input  wire logic                         CMP_HI_WR_I,
   input  wire logic [7:0]                   CMP_WDATA_I,
   output logic [15:0]                       CMP_RDATA_O,
   // Full-duty bits
   input  wire logic                         FULL_DUTY_WR_I,
   input  wire logic [2:0]                   FULL_DUTY_I,
   output logic [2:0]                        PHASE_FULL_DUTY_O,
   // Update flag
   input  wire logic                         UPDATE_CLR_I,
   input  wire logic                         UPDATE_MASK_I,
   output logic                              UPDATE_FLAG_O,
   output logic                              UPDATE_IRQ_O,
   // Status and drive
   output logic [tpc_pkg::CNT_W-1:0]         COUNTER_O,
   output logic [2:0]                        PHASE_PWM_O,
   output logic [5:0]                        MOTOR_DRIVE_OUT_O
);
   import tpc_pkg::*;

   // =====================================================================
   // Declarations
   logic [7:0]        pre_lo_ff  [4];
   logic [7:0]        pre_hi_ff  [4];
   logic [3:0]        pend_ff;
   logic [3:0]        defer_ff;
   logic [7:0]        nxt_pre_lo [4];
   logic [7:0]        nxt_pre_hi [4];
   logic [3:0]        nxt_pend;
   logic [3:0]        nxt_defer;
   logic [3:0]        load;

   logic [CNT_W-1:0]  act_per_ff;
   logic [DUTY_W-1:0] act_duty_ff [3];
   tpc_timebase_t     act_tb_ff;
   logic [2:0]        pre_ovf_ff;
   logic [2:0]        act_ovf_ff;
   logic [CNT_W-1:0]  nxt_act_per;
   logic [DUTY_W-1:0] nxt_act_duty [3];
   tpc_timebase_t     nxt_act_tb;
   logic [2:0]        nxt_pre_ovf;
   logic [2:0]        nxt_act_ovf;

   logic [PRE_W-1:0]  pre_cnt_ff;
   logic [CNT_W-1:0]  cnt_ff;
   tpc_dir_t          dir_ff;
   logic [REP_W-1:0]  rep_ff;
   logic              cke_d_ff;
   logic              flag_ff;
   logic [PRE_W-1:0]  nxt_pre_cnt;
   logic [CNT_W-1:0]  nxt_cnt;
   tpc_dir_t          nxt_dir;
   logic [REP_W-1:0]  nxt_rep;
   logic              nxt_flag;
   logic              tick;
   logic              wrap;
   logic              upd;

   logic [2:0]        pwm_ff;
   logic [2:0]        nxt_pwm;
   logic [5:0]        out_ff;
   logic [5:0]        nxt_out;
   logic [15:0]       rdata_ff;
   logic [15:0]       nxt_rdata;
   logic              chop;

   // =====================================================================
   // Preload registers
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         nxt_pre_lo[i] = pre_lo_ff[i];
         nxt_pre_hi[i] = pre_hi_ff[i];
         nxt_pend[i]   = pend_ff[i];
         nxt_defer[i]  = defer_ff[i];
         load[i]       = 1'b0;
         if (CMP_SEL_I == 2'(i) && CMP_LO_WR_I) begin
            nxt_pre_lo[i] = CMP_WDATA_I;
            nxt_pend[i]   = ~TIMEBASE_I.byte_wide;
         end
         if (CMP_SEL_I == 2'(i) && CMP_HI_WR_I) begin
            nxt_pre_hi[i] = CMP_WDATA_I;
            nxt_pend[i]   = 1'b0;
         end
         if (upd && !pend_ff[i]) begin
            load[i]      = 1'b1;
            nxt_defer[i] = 1'b0;
         end else if (upd) begin
            nxt_defer[i] = 1'b1;
         end else if (defer_ff[i] && !pend_ff[i]) begin
            load[i]      = 1'b1;
            nxt_defer[i] = 1'b0;
         end
      end
      nxt_pre_ovf = upd ? 3'h0 : pre_ovf_ff;
      if (FULL_DUTY_WR_I) begin
         nxt_pre_ovf = FULL_DUTY_I;
      end
   end

   // =====================================================================
   // Active registers
   always_comb begin
      nxt_act_per = act_per_ff;
      nxt_act_tb  = upd ? TIMEBASE_I : act_tb_ff;
      nxt_act_ovf = upd ? pre_ovf_ff : act_ovf_ff;
      if (load[0]) begin
         nxt_act_per = TIMEBASE_I.byte_wide ? {4'h0, pre_lo_ff[0]}
                                            : {pre_hi_ff[0][3:0], pre_lo_ff[0]};
      end
      for (int p = 0; p < 3; p++) begin
         nxt_act_duty[p] = act_duty_ff[p];
         if (load[p+1]) begin
            nxt_act_duty[p] = TIMEBASE_I.byte_wide ? {5'h00, pre_lo_ff[p+1]}
                              : round13({pre_hi_ff[p+1], pre_lo_ff[p+1]});
         end
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         for (int i = 0; i < 4; i++) begin
            pre_lo_ff[i] <= 8'h00;
            pre_hi_ff[i] <= 8'h00;
         end
         for (int p = 0; p < 3; p++) begin
            act_duty_ff[p] <= DUTY_RST;
         end
         pend_ff    <= 4'h0;
         defer_ff   <= 4'h0;
         act_per_ff <= PERIOD_RST;
         act_tb_ff  <= '0;
         pre_ovf_ff <= 3'h0;
         act_ovf_ff <= 3'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            pre_lo_ff[i] <= nxt_pre_lo[i];
            pre_hi_ff[i] <= nxt_pre_hi[i];
         end
         for (int p = 0; p < 3; p++) begin
            act_duty_ff[p] <= nxt_act_duty[p];
         end
         pend_ff    <= nxt_pend;
         defer_ff   <= nxt_defer;
         act_per_ff <= nxt_act_per;
         act_tb_ff  <= nxt_act_tb;
         pre_ovf_ff <= nxt_pre_ovf;
         act_ovf_ff <= nxt_act_ovf;
      end
   end

   // =====================================================================
   // Prescaler, counter, repetition and update
   always_comb begin
      nxt_pre_cnt = pre_cnt_ff;
      nxt_cnt     = cnt_ff;
      nxt_dir     = dir_ff;
      nxt_rep     = rep_ff;
      tick        = 1'b0;
      wrap        = 1'b0;
      if (!CLK_EN_I) begin
         nxt_pre_cnt = '0;
         nxt_cnt     = '0;
         nxt_dir     = CNT_UP;
      end else begin
         tick        = (pre_cnt_ff >= act_tb_ff.prescale);
         nxt_pre_cnt = tick ? '0 : pre_cnt_ff + PRE_W'(1);
      end
      if (tick) begin
         if (!act_tb_ff.center) begin
            if (cnt_ff >= act_per_ff) begin
               nxt_cnt = '0;
               wrap    = 1'b1;
            end else begin
               nxt_cnt = cnt_ff + CNT_W'(1);
            end
         end else if (dir_ff == CNT_UP) begin
            if (cnt_ff >= act_per_ff) begin
               nxt_dir = CNT_DOWN;
               nxt_cnt = cnt_ff - CNT_W'(1);
               wrap    = 1'b1;
            end else begin
               nxt_cnt = cnt_ff + CNT_W'(1);
            end
         end else begin
            if (cnt_ff == '0) begin
               nxt_dir = CNT_UP;
               nxt_cnt = CNT_W'(1);
               wrap    = 1'b1;
            end else begin
               nxt_cnt = cnt_ff - CNT_W'(1);
            end
         end
      end
      upd = (CLK_EN_I && !cke_d_ff) || (wrap && rep_ff == '0);
      if (CLK_EN_I && !cke_d_ff) begin
         nxt_rep = REPEAT_COUNT_I;
      end else if (wrap) begin
         nxt_rep = (rep_ff == '0) ? REPEAT_COUNT_I : rep_ff - REP_W'(1);
      end
      nxt_flag = (flag_ff && !UPDATE_CLR_I) || upd;
   end

   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         pre_cnt_ff <= '0;
         cnt_ff     <= '0;
         dir_ff     <= CNT_UP;
         rep_ff     <= '0;
         cke_d_ff   <= 1'b0;
         flag_ff    <= 1'b0;
      end else begin
         pre_cnt_ff <= nxt_pre_cnt;
         cnt_ff     <= nxt_cnt;
         dir_ff     <= nxt_dir;
         rep_ff     <= nxt_rep;
         cke_d_ff   <= CLK_EN_I;
         flag_ff    <= nxt_flag;
      end
   end

   // =====================================================================
   // Phase compare
   always_comb begin
      for (int p = 0; p < 3; p++) begin
         nxt_pwm[p] = CLK_EN_I && ({1'b0, cnt_ff} < act_duty_ff[p]);
         if (CLK_EN_I && act_tb_ff.byte_wide && act_ovf_ff[p]) begin
            nxt_pwm[p] = 1'b1;
         end
      end
   end

   // =====================================================================
   // Chopper and channel routing
   tpc_chop_gen u_chop (
      .CLK_SYS_I  (CLK_SYS_I),
      .RSTN_I     (RSTN_I),
      .EN_I       (CLK_EN_I),
      .FREQ_SEL_I (CHOP_CFG_I.freq_sel),
      .CHOP_O     (chop)
   );

   for (genvar c = 0; c < 6; c++) begin : g_chan
      logic ph;
      logic paired;
      logic is_high;
      logic raw;
      logic sel;
      assign ph      = CHOP_CFG_I.three_route ? pwm_ff[c/2] : pwm_ff[0];
      assign paired  = CHOP_CFG_I.three_route || CHOP_CFG_I.compl_en;
      assign is_high = paired ? (c % 2 == 0) : CHOP_CFG_I.polarity[c];
      assign raw     = (paired && (c % 2 == 1)) ? ~ph : ph;
      assign sel     = is_high ? CHOP_CFG_I.chan_sel[CHOP_HIGH_BIT]
                               : CHOP_CFG_I.chan_sel[CHOP_LOW_BIT];
      assign nxt_out[c] = CLK_EN_I && raw && (!sel || chop);
   end

   // =====================================================================
   // Read back and output registers
   always_comb begin
      nxt_rdata = {pre_hi_ff[CMP_SEL_I], pre_lo_ff[CMP_SEL_I]};
   end

   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         pwm_ff   <= 3'h0;
         out_ff   <= 6'h00;
         rdata_ff <= 16'h0000;
      end else begin
         pwm_ff   <= nxt_pwm;
         out_ff   <= nxt_out;
         rdata_ff <= nxt_rdata;
      end
   end

   assign CMP_RDATA_O       = rdata_ff;
   assign PHASE_FULL_DUTY_O = pre_ovf_ff;
   assign UPDATE_FLAG_O     = flag_ff;
   assign UPDATE_IRQ_O      = flag_ff && UPDATE_MASK_I;
   assign COUNTER_O         = cnt_ff;
   assign PHASE_PWM_O       = pwm_ff;
   assign MOTOR_DRIVE_OUT_O = out_ff;

endmodule : tpc_pwm_gen

// [rtl/tpc_pkg.sv]
// Purpose: Shared constants and types for the three-phase PWM generator
// Assumes: 40 MHz system clock
// Notes:   Chopper rates are held in kHz and turned into half-period counts

package tpc_pkg;

   // =====================================================================
   // Clock and widths
   localparam int CLK_KHZ = 40000;
   localparam int CNT_W   = 12;
   localparam int DUTY_W  = 13;
   localparam int REP_W   = 8;
   localparam int PRE_W   = 3;
   localparam int CHOP_W  = 8;

   // =====================================================================
   // Compare pair selects
   localparam logic [1:0] SEL_PERIOD = 2'h0;
   localparam logic [1:0] SEL_U      = 2'h1;
   localparam logic [1:0] SEL_V      = 2'h2;
   localparam logic [1:0] SEL_W      = 2'h3;

   // =====================================================================
   // Chopper channel select bits and rates
   localparam int CHOP_LOW_BIT  = 0;
   localparam int CHOP_HIGH_BIT = 1;
   localparam int CHOP_KHZ [8]  = '{100, 200, 400, 500, 800, 1000, 1333, 2000};

   // =====================================================================
   // Reset values, duty limit and rounding bits
   localparam logic [CNT_W-1:0]  PERIOD_RST = 12'hFFF;
   localparam logic [DUTY_W-1:0] DUTY_RST   = 13'h0000;
   localparam logic [DUTY_W-1:0] DUTY_MAX   = 13'h1FFF;
   localparam int                RND_BIT    = 2;
   localparam int                DUTY_LSB   = 3;

   // =====================================================================
   // Types
   typedef enum logic {CNT_UP, CNT_DOWN} tpc_dir_t;

   typedef struct packed {
      logic [1:0] chan_sel;
      logic [2:0] freq_sel;
      logic       three_route;
      logic       compl_en;
      logic [5:0] polarity;
   } tpc_chop_cfg_t;

   typedef struct packed {
      logic [PRE_W-1:0] prescale;
      logic             center;
      logic             byte_wide;
   } tpc_timebase_t;

   // Half period of the chopping square wave in system clocks
   function automatic logic [CHOP_W-1:0] chop_half(input logic [2:0] code);
      int khz;
      khz = CHOP_KHZ[code];
      return CHOP_W'(CLK_KHZ / (2 * khz));
   endfunction : chop_half

   // Left-aligned 16-bit pair rounded to 13 bits, saturating
   function automatic logic [DUTY_W-1:0] round13(input logic [15:0] pair);
      logic [DUTY_W:0] sum;
      sum = {1'b0, pair[15:DUTY_LSB]} + {13'h0000, pair[RND_BIT]};
      return sum[DUTY_W] ? DUTY_MAX : sum[DUTY_W-1:0];
   endfunction : round13

endpackage : tpc_pkg

// [rtl/tpc_chop_gen.sv]
// Purpose: 50% square wave at the selected chopping rate
// Assumes: Rate code is stable while enabled
// Notes:   Idles high so that gated outputs pass unchanged

`timescale 1ns/100ps

module tpc_chop_gen (
   // Clock and reset
   input  wire logic       CLK_SYS_I,
   input  wire logic       RSTN_I,
   // Control
   input  wire logic       EN_I,
   input  wire logic [2:0] FREQ_SEL_I,
   // Wave
   output logic            CHOP_O
);
   import tpc_pkg::*;

   logic [CHOP_W-1:0] cnt_ff;
   logic [CHOP_W-1:0] nxt_cnt;
   logic              wave_ff;
   logic              nxt_wave;

   // =====================================================================
   // Divider
   always_comb begin
      nxt_cnt  = cnt_ff;
      nxt_wave = wave_ff;
      if (!EN_I) begin
         nxt_cnt  = '0;
         nxt_wave = 1'b1;
      end else if (cnt_ff >= chop_half(FREQ_SEL_I) - CHOP_W'(1)) begin
         nxt_cnt  = '0;
         nxt_wave = ~wave_ff;
      end else begin
         nxt_cnt = cnt_ff + CHOP_W'(1);
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         cnt_ff  <= '0;
         wave_ff <= 1'b1;
      end else begin
         cnt_ff  <= nxt_cnt;
         wave_ff <= nxt_wave;
      end
   end

   assign CHOP_O = wave_ff;

endmodule : tpc_chop_gen

// [verification/tpc_pwm_chk.sv]
// Purpose: Port assertions for the three-phase PWM generator
// Assumes: Bound to tpc_pwm_gen; one clock domain
// Notes:   Drive checks cover three-signal routing only
`timescale 1ns/100ps
module tpc_pwm_chk (
   // Clock and reset
   input wire logic                   CLK_SYS_I,
   input wire logic                   RSTN_I,
   // Inputs
   input wire logic                   CLK_EN_I,
   input wire tpc_pkg::tpc_chop_cfg_t CHOP_CFG_I,
   input wire logic [1:0]             CMP_SEL_I,
   input wire logic                   CMP_HI_WR_I,
   input wire logic [7:0]             CMP_WDATA_I,
   input wire logic                   FULL_DUTY_WR_I,
   input wire logic [2:0]             FULL_DUTY_I,
   input wire logic                   UPDATE_CLR_I,
   input wire logic                   UPDATE_MASK_I,
   // Outputs
   input wire logic [15:0]            CMP_RDATA_O,
   input wire logic [2:0]             PHASE_FULL_DUTY_O,
   input wire logic                   UPDATE_FLAG_O,
   input wire logic                   UPDATE_IRQ_O,
   input wire logic [11:0]            COUNTER_O,
   input wire logic [2:0]             PHASE_PWM_O,
   input wire logic [5:0]             MOTOR_DRIVE_OUT_O
);
   import tpc_pkg::*;
   // ==========
   // Timing defaults
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RSTN_I);
   // ==========
   // Counter and update
   chk_hold_zero:
   assert property (!CLK_EN_I |=> COUNTER_O == 12'h000) else $error("counter not held");
   chk_enable_update:
   assert property ($rose(CLK_EN_I) |=> UPDATE_FLAG_O) else $error("no update on enable");
   chk_irq_mask:
   assert property (UPDATE_IRQ_O == (UPDATE_FLAG_O & UPDATE_MASK_I)) else $error("irq mask");
   chk_flag_clear:
   assert property ($fell(UPDATE_FLAG_O) |-> $past(UPDATE_CLR_I)) else $error("flag lost");
   chk_count_step:
   assert property ($changed(COUNTER_O) && COUNTER_O != 12'h000 |->
      COUNTER_O == $past(COUNTER_O) + 12'h001 || COUNTER_O == $past(COUNTER_O) - 12'h001)
      else $error("counter jump");
   // ==========
   // Preload side
   chk_full_duty_wr:
   assert property (FULL_DUTY_WR_I |=> PHASE_FULL_DUTY_O == $past(FULL_DUTY_I))
      else $error("full duty preload");
   chk_read_preload:
   assert property (CMP_HI_WR_I && CMP_SEL_I != SEL_PERIOD ##1 !CMP_HI_WR_I &&
      $stable(CMP_SEL_I) ##1 $stable(CMP_SEL_I) |-> CMP_RDATA_O[15:8] == $past(CMP_WDATA_I, 2))
      else $error("readback not preload");
   // ==========
   // Drive outputs
   chk_high_plain:
   assert property ($past(CLK_EN_I) && $past(CHOP_CFG_I.three_route) &&
      !$past(CHOP_CFG_I.chan_sel[1]) |-> {MOTOR_DRIVE_OUT_O[4], MOTOR_DRIVE_OUT_O[2],
      MOTOR_DRIVE_OUT_O[0]} == $past(PHASE_PWM_O)) else $error("high side altered");
   chk_low_plain:
   assert property ($past(RSTN_I) && $past(CLK_EN_I) && $past(CHOP_CFG_I.three_route) &&
      !$past(CHOP_CFG_I.chan_sel[0]) |-> {MOTOR_DRIVE_OUT_O[5], MOTOR_DRIVE_OUT_O[3],
      MOTOR_DRIVE_OUT_O[1]} == ~$past(PHASE_PWM_O)) else $error("low side altered");
   chk_chop_gate:
   assert property ($past(CHOP_CFG_I.three_route) |-> ({MOTOR_DRIVE_OUT_O[4],
      MOTOR_DRIVE_OUT_O[2], MOTOR_DRIVE_OUT_O[0]} & ~$past(PHASE_PWM_O)) == 3'h0)
      else $error("chopper raised a low phase");
endmodule : tpc_pwm_chk

// [verification/tpc_gate_drv.sv]
// Purpose: Gate driver stand-in recording high-pulse widths
// Assumes: Lines sampled on the system clock
// Notes:   A line that never falls reports zero
`timescale 1ns/100ps
module tpc_gate_drv (
   // Clock and control
   input  wire logic       clk_i,
   input  wire logic       clr_i,
   // Gate lines
   input  wire logic [5:0] gate_i,
   // Last finished high run
   output int              run_o [6]
);
   int cur [6];
   // ==========
   // Width capture
   always @(posedge clk_i) begin
      for (int i = 0; i < 6; i++) begin
         if (clr_i) begin
            cur[i] <= 0;
            run_o[i] <= 0;
         end else if (gate_i[i] === 1'b1) begin
            cur[i] <= cur[i] + 1;
         end else begin
            cur[i] <= 0;
            if (cur[i] != 0) run_o[i] <= cur[i];
         end
      end
   end
endmodule : tpc_gate_drv

// [verification/tb.sv]
// Purpose: Self-checking bench for the three-phase PWM generator
// Assumes: Period 20, no dead time
// Notes:   Inputs change on the falling edge
`timescale 1ns/100ps
`define CHK(a, b) \
   begin \
      compares++; \
      if ((a) !== (b)) begin \
         n_errors++; \
         $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (b)); \
      end \
   end
module tb;
   import tpc_pkg::*;
   logic clk, rstn, en, lo_wr, hi_wr, fd_wr, clr, mask, dclr, flag, irq;
   logic [7:0] rep, wdata;
   logic [1:0] sel;
   logic [2:0] fd, fdo, pwm;
   logic [15:0] rdata;
   logic [11:0] cnt;
   logic [5:0] motor_drive_out;
   tpc_timebase_t tbase;
   tpc_chop_cfg_t cfg;
   int run [6];
   int h [3];
   int pk;
   int n_errors = 0;
   int compares = 0;
   int khz [8] = '{100, 200, 400, 500, 800, 1000, 1333, 2000};
   // ==========
   // Design and far side
   tpc_pwm_gen dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .CLK_EN_I(en), .TIMEBASE_I(tbase),
      .CHOP_CFG_I(cfg), .REPEAT_COUNT_I(rep), .CMP_SEL_I(sel), .CMP_LO_WR_I(lo_wr),
      .CMP_HI_WR_I(hi_wr), .CMP_WDATA_I(wdata), .CMP_RDATA_O(rdata), .FULL_DUTY_WR_I(fd_wr),
      .FULL_DUTY_I(fd), .PHASE_FULL_DUTY_O(fdo), .UPDATE_CLR_I(clr), .UPDATE_MASK_I(mask),
      .UPDATE_FLAG_O(flag), .UPDATE_IRQ_O(irq), .COUNTER_O(cnt), .PHASE_PWM_O(pwm),
      .MOTOR_DRIVE_OUT_O(motor_drive_out));
   tpc_gate_drv drv (.clk_i(clk), .clr_i(dclr), .gate_i(motor_drive_out), .run_o(run));
   // ==========
   // Helpers
   task automatic end_sim;
      $display("compares=%0d n_errors=%0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_sim
   task automatic wr_pair(input logic [1:0] s, input logic [15:0] v);
      @(negedge clk);
      sel = s;
      wdata = v[7:0];
      lo_wr = 1'b1;
      @(negedge clk);
      lo_wr = 1'b0;
      wdata = v[15:8];
      hi_wr = 1'b1;
      @(negedge clk);
      hi_wr = 1'b0;
   endtask : wr_pair
   task automatic restart(input tpc_timebase_t t, input tpc_chop_cfg_t c);
      @(negedge clk);
      en = 1'b0;
      tbase = t;
      cfg = c;
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      @(negedge clk);
      en = 1'b1;
      repeat (4) @(negedge clk);
      dclr = 1'b1;
      @(negedge clk);
      dclr = 1'b0;
   endtask : restart
   task automatic meas(input int n);
      h = '{0, 0, 0};
      pk = 0;
      repeat (n) begin
         @(negedge clk);
         for (int i = 0; i < 3; i++) h[i] += int'(pwm[i] === 1'b1);
         if (int'(cnt) > pk) pk = int'(cnt);
      end
   endtask : meas
   // ==========
   // Scenarios
   task automatic t_edge;
      `CHK(cnt, 12'h000)
      wr_pair(SEL_PERIOD, 16'h0014);
      wr_pair(SEL_U, 16'h0050);
      wr_pair(SEL_V, 16'h0000);
      wr_pair(SEL_W, 16'h00F0);
      sel = SEL_U;
      repeat (2) @(negedge clk);
      `CHK(rdata, 16'h0050)
      mask = 1'b1;
      restart(5'h00, 13'h0080);
      `CHK(flag, 1'b1)
      `CHK(irq, 1'b1)
      mask = 1'b0;
      @(negedge clk);
      `CHK(irq, 1'b0)
      mask = 1'b1;
      meas(21);
      `CHK(h[0], 10)
      `CHK(h[1], 0)
      `CHK(h[2], 21)
      `CHK(pk, 20)
      while (cnt !== 12'h003) @(negedge clk);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      `CHK(flag, 1'b0)
      $display("test edge done");
   endtask : t_edge
   task automatic t_preload;
      wdata = 8'h2C;
      lo_wr = 1'b1;
      @(negedge clk);
      lo_wr = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(rdata, 16'h002C)
      meas(42);
      `CHK(h[0], 20)
      wdata = 8'h00;
      hi_wr = 1'b1;
      @(negedge clk);
      hi_wr = 1'b0;
      repeat (21) @(negedge clk);
      meas(42);
      `CHK(h[0], 12)
      restart(5'h02, 13'h0080);
      meas(40);
      `CHK(h[0], 11)
      `CHK(pk, 20)
      restart(5'h08, 13'h0080);
      meas(63);
      `CHK(h[0], 18)
      `CHK(h[2], 63)
      $display("test preload done");
   endtask : t_preload
   task automatic t_byte;
      en = 1'b0;
      rep = 8'd3;
      wr_pair(SEL_U, 16'h0007);
      wr_pair(SEL_W, 16'h0003);
      fd = 3'b100;
      fd_wr = 1'b1;
      @(negedge clk);
      fd_wr = 1'b0;
      `CHK(fdo, 3'b100)
      restart(5'h01, 13'h0080);
      `CHK(fdo, 3'b000)
      meas(42);
      `CHK(h[2], 42)
      `CHK(h[0], 14)
      repeat (60) @(negedge clk);
      meas(42);
      `CHK(h[2], 6)
      rep = 8'd0;
      $display("test byte done");
   endtask : t_byte
   task automatic t_chop;
      en = 1'b0;
      wr_pair(SEL_U, 16'h8000);
      wr_pair(SEL_V, 16'h0000);
      for (int k = 0; k < 8; k++) begin
         restart(5'h00, {2'b11, 3'(k), 1'b1, 1'b0, 6'h00});
         repeat (80000 / khz[k] + 20) @(negedge clk);
         `CHK(run[0], 20000 / khz[k])
      end
      for (int j = 0; j < 4; j++) begin
         restart(5'h00, {2'(j), 3'h7, 1'b1, 1'b0, 6'h00});
         repeat (60) @(negedge clk);
         `CHK(run[0], j[1] ? 10 : 0)
         `CHK(run[3], j[0] ? 10 : 0)
      end
      restart(5'h00, {2'b10, 3'h7, 1'b0, 1'b0, 6'h01});
      repeat (60) @(negedge clk);
      `CHK(run[0], 10)
      `CHK(motor_drive_out[1], 1'b1)
      restart(5'h00, {2'b10, 3'h7, 1'b0, 1'b1, 6'h00});
      repeat (60) @(negedge clk);
      `CHK(run[0], 10)
      `CHK(motor_drive_out[1], 1'b0)
      $display("test chop done");
   endtask : t_chop
   // ==========
   // Clock, watchdog, sequence
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      n_errors++;
      end_sim();
   end
   initial begin
      {rstn, en, lo_wr, hi_wr, fd_wr, clr, mask, dclr} = 8'h00;
      {rep, wdata, sel, fd} = 21'h0_0000;
      tbase = 5'h00;
      cfg = 13'h0000;
      repeat (16) @(posedge clk);
      @(negedge clk);
      rstn = 1'b1;
      t_edge();
      t_preload();
      t_byte();
      t_chop();
      end_sim();
   end
endmodule : tb
bind tpc_pwm_gen tpc_pwm_chk chk (.CLK_SYS_I, .RSTN_I, .CLK_EN_I, .CHOP_CFG_I, .CMP_SEL_I,
   .CMP_HI_WR_I, .CMP_WDATA_I, .FULL_DUTY_WR_I, .FULL_DUTY_I, .UPDATE_CLR_I, .UPDATE_MASK_I,
   .CMP_RDATA_O, .PHASE_FULL_DUTY_O, .UPDATE_FLAG_O, .UPDATE_IRQ_O, .COUNTER_O, .PHASE_PWM_O,
   .MOTOR_DRIVE_OUT_O);
